// file: rtl/acp_pkg.sv
// ============================================================
// shared constants and types for the converter control pins
package acp_pkg;

	// ============================================================
	// sizes
	localparam int unsigned CHANNELS  = 6;
	localparam int unsigned HALF_CH   = 3;
	localparam int unsigned WORD_W    = 16;
	localparam int unsigned PIN_W     = 10;
	localparam int unsigned BIT_LAST  = 15;

	// ============================================================
	// timing: internal conversion time, and clock period
	localparam int unsigned CLK_PERIOD_NS = 40;
	localparam int unsigned CONV_TIME_NS  = 3000;
	// a least time, so round up to whole cycles
	localparam int unsigned CONV_CYCLES   =
		(CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CNT_W         = 8;

	// ============================================================
	// reset values and fixed levels
	localparam logic [WORD_W-1:0] WORD_ZERO    = 16'h0000;
	localparam logic [WORD_W-1:0] OE_ALL       = 16'hffff;
	localparam logic [WORD_W-1:0] OE_BYTE      = 16'h00ff;
	localparam logic [WORD_W-1:0] OE_NONE      = 16'h0000;
	localparam logic [7:0]        BYTE_ZERO    = 8'h00;
	// synchroniser reset levels: standby, chip select and strobe idle high
	localparam logic [PIN_W-1:0]  PINS_IDLE    = 10'h083;
	// range level that picks standby when the standby pin is low
	localparam logic              STANDBY_N_INPUT_RANGE   = 1'b1;
	// byte mode sends the upper byte of each word first
	localparam logic              BYTE_MSB_1ST = 1'b1;

	// ============================================================
	// types
	typedef enum logic [1:0] {
		MODE_PAR,
		MODE_BYTE,
		MODE_SER
	} acp_mode_t;

	typedef enum logic [1:0] {
		PWR_NORMAL,
		PWR_STANDBY,
		PWR_SHUTDOWN
	} acp_power_t;

	typedef enum logic {
		CONV_IDLE,
		CONV_RUN
	} acp_conv_t;

	// all pins that enter from the host, in synchroniser order
	typedef struct packed {
		logic referenceSelect;
		logic rangeSelect;
		logic standbyN;
		logic interfaceSelect;
		logic byteModeSelect;
		logic conversionStartA;
		logic conversionStartB;
		logic resetPin;
		logic csN;
		logic rdSclk;
	} acp_pins_t;

	// power and analog steering levels
	typedef struct packed {
		logic       internalRefEn;
		logic       bandgapOn;
		logic       refBufferOn;
		logic       regulatorsOn;
		logic       rangeTenVolt;
		acp_power_t powerState;
	} acp_analog_t;

endpackage

// file: rtl/acp_sync.sv
`timescale 1ns/10ps
// ============================================================
// two-flop synchroniser for a bundle of pins
module acp_sync #(
	parameter int unsigned      WIDTH     = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input  wire logic             clk_sys,
	input  wire logic             resetn,
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] meta_q;

	// first stage feeds only the second stage
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clk_sys or negedge resetn) begin
				if (!resetn) begin
					// idle level, so no false edge follows reset
					meta_q[i]  <= RESET_VAL[i];
					syncOut[i] <= RESET_VAL[i];
				end else begin
					meta_q[i]  <= asyncIn[i];
					syncOut[i] <= meta_q[i];
				end
			end
		end
	endgenerate
endmodule // acp_sync

// file: rtl/acp_control_pins.sv
`timescale 1ns/10ps
// Functional notes
// [RULE1] reference select high enables internal reference
// [RULE2] reference buffer always stays enabled; the code turns it off in shutdown
// [RULE3] reference select acts immediately, power-up follows it
// [RULE4] range high gives ten volt, low five
// [RULE5] host waits extra settling after range change
// [RULE6] standby low enters standby or shutdown
// [RULE7] shutdown powers all, standby keeps reference
// [RULE8] host waits recovery after leaving power-down
// [RULE9] interface and byte select choose readout mode
// [RULE10] start A holds channels 1-3, B 4-6
// [RULE11] oversampling needs both starts tied together
// [RULE12] start rising edge holds group, then converts
// [RULE13] host lowers starts only after busy falls
// [RULE14] readout works whatever the start levels
// [RULE15] reset pin clears logic while held high
// [RULE16] host resets after power-up and shutdown
// [RULE17] reset during conversion aborts, data invalid
// [RULE18] reset during read zeroes output registers
// [RULE19] host keeps delay from reset to start
// [RULE20] parallel modes: read strobe, bus driven when selected
// [RULE21] serial mode: serial clock, rising edge timing
// [RULE22] busy after both starts, starts ignored meanwhile
// [RULE23] chip select fall starts frame, rise tristates
// [RULE24] asynchronous pins synchronised before use
module acp_control_pins (
	input  wire logic                         clk_sys,
	input  wire logic                         resetn,
	input  wire logic                         referenceSelect,
	input  wire logic                         rangeSelect,
	input  wire logic                         standbyN,
	input  wire logic                         interfaceSelect,
	input  wire logic                         byteModeSelect,
	input  wire logic                         conversionStartA,
	input  wire logic                         conversionStartB,
	input  wire logic                         resetPin,
	input  wire logic                         csN,
	input  wire logic                         rdSclk,
	input  wire logic [acp_pkg::CHANNELS*acp_pkg::WORD_W-1:0] convResult,
	output logic                              busy,
	output logic                              holdA,
	output logic                              holdB,
	output logic                              dataValid,
	output acp_pkg::acp_analog_t              analog,
	output logic      [acp_pkg::WORD_W-1:0]   dbOut,
	output logic      [acp_pkg::WORD_W-1:0]   dbOe,
	output logic                              doutA,
	output logic                              doutB,
	output logic                              doutOe,
	output logic                              firstData
);
	// ============================================================
	// pin synchronisation and edge detection
	acp_pkg::acp_pins_t pinsRaw;
	acp_pkg::acp_pins_t pinsS;
	acp_pkg::acp_pins_t pinsPrev_q;

	assign pinsRaw = '{referenceSelect, rangeSelect, standbyN, interfaceSelect,
		byteModeSelect, conversionStartA, conversionStartB, resetPin, csN, rdSclk};

	// every host pin passes two flops, the serial clock included
	acp_sync #(.WIDTH(acp_pkg::PIN_W), .RESET_VAL(acp_pkg::PINS_IDLE)) uSync (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.asyncIn (pinsRaw),
		.syncOut (pinsS)
	); // RULE24

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pinsPrev_q <= acp_pkg::PINS_IDLE;
		end else begin
			pinsPrev_q <= pinsS;
		end
	end

	wire startARise = pinsS.conversionStartA & ~pinsPrev_q.conversionStartA;
	wire startBRise = pinsS.conversionStartB & ~pinsPrev_q.conversionStartB;
	wire csFall     = ~pinsS.csN & pinsPrev_q.csN;
	wire csRise     = pinsS.csN & ~pinsPrev_q.csN;
	wire rdFall     = ~pinsS.rdSclk & pinsPrev_q.rdSclk;
	wire sclkRise   = pinsS.rdSclk & ~pinsPrev_q.rdSclk;
	wire digReset   = pinsS.resetPin; // RULE15

	// ============================================================
	// mode decode
	function automatic acp_pkg::acp_mode_t decodeMode(input logic ifSel, input logic bSel);
		if (!ifSel) begin
			decodeMode = acp_pkg::MODE_PAR;
		end else if (bSel) begin
			decodeMode = acp_pkg::MODE_BYTE;
		end else begin
			decodeMode = acp_pkg::MODE_SER;
		end
	endfunction

	function automatic acp_pkg::acp_power_t decodePower(input logic stbyN, input logic rng);
		if (stbyN) begin
			decodePower = acp_pkg::PWR_NORMAL;
		end else if (rng == acp_pkg::STANDBY_N_INPUT_RANGE) begin
			decodePower = acp_pkg::PWR_STANDBY;
		end else begin
			decodePower = acp_pkg::PWR_SHUTDOWN;
		end
	endfunction

	wire acp_pkg::acp_mode_t  mode     = decodeMode(pinsS.interfaceSelect,
		pinsS.byteModeSelect); // RULE9
	wire acp_pkg::acp_power_t powerNow = decodePower(pinsS.standbyN,
		pinsS.rangeSelect); // RULE6
	wire isSerial = (mode == acp_pkg::MODE_SER);
	wire isByte   = (mode == acp_pkg::MODE_BYTE);
	wire shutdown = (powerNow == acp_pkg::PWR_SHUTDOWN);

	// ============================================================
	// analog steering; follows the pins every cycle, so power-up
	// settles in whatever mode the pins show after reset release
	acp_pkg::acp_analog_t analogD;
	assign analogD.internalRefEn = pinsS.referenceSelect; // RULE1 RULE3
	assign analogD.bandgapOn     = pinsS.referenceSelect & ~shutdown; // RULE1 RULE7
	assign analogD.refBufferOn   = ~shutdown; // RULE2
	assign analogD.regulatorsOn  = ~shutdown; // RULE7
	assign analogD.rangeTenVolt  = pinsS.rangeSelect; // RULE4
	assign analogD.powerState    = powerNow;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			analog <= '0;
		end else begin
			analog <= analogD;
		end
	end

	// ============================================================
	// conversion control
	acp_pkg::acp_conv_t               convState_q;
	logic [acp_pkg::CNT_W-1:0]        convCnt_q;
	logic [acp_pkg::WORD_W-1:0]       results_q [acp_pkg::CHANNELS];
	wire gotA    = holdA | startARise;
	wire gotB    = holdB | startBRise;
	wire convEnd = (convState_q == acp_pkg::CONV_RUN) &&
		(convCnt_q == acp_pkg::CNT_W'(acp_pkg::CONV_CYCLES - 1));

	// a group enters hold on its own edge; busy needs both
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			convState_q <= acp_pkg::CONV_IDLE;
			convCnt_q   <= '0;
			holdA       <= 1'b0;
			holdB       <= 1'b0;
			busy        <= 1'b0;
			dataValid   <= 1'b0;
		end else if (digReset) begin
			convState_q <= acp_pkg::CONV_IDLE; // RULE17
			convCnt_q   <= '0;
			holdA       <= 1'b0;
			holdB       <= 1'b0;
			busy        <= 1'b0;
			dataValid   <= 1'b0; // RULE17
		end else begin
			case (convState_q)
				acp_pkg::CONV_IDLE: begin
					holdA <= gotA; // RULE10 RULE12
					holdB <= gotB; // RULE10 RULE12
					if (gotA && gotB) begin
						convState_q <= acp_pkg::CONV_RUN;
						convCnt_q   <= '0;
						busy        <= 1'b1; // RULE22
					end
				end
				acp_pkg::CONV_RUN: begin
					// start edges are not looked at here
					convCnt_q <= convCnt_q + 1'b1; // RULE22
					if (convEnd) begin
						convState_q <= acp_pkg::CONV_IDLE;
						holdA       <= 1'b0;
						holdB       <= 1'b0;
						busy        <= 1'b0; // RULE22
						dataValid   <= 1'b1;
					end
				end
				default: begin
					convState_q <= acp_pkg::CONV_IDLE;
				end
			endcase
		end
	end

	// results latch when conversion ends; reset pin zeroes them
	genvar g;
	generate
		for (g = 0; g < acp_pkg::CHANNELS; g++) begin : g_res
			always_ff @(posedge clk_sys or negedge resetn) begin
				if (!resetn) begin
					results_q[g] <= acp_pkg::WORD_ZERO;
				end else if (digReset) begin
					results_q[g] <= acp_pkg::WORD_ZERO; // RULE18
				end else if (convEnd) begin
					results_q[g] <= convResult[g*acp_pkg::WORD_W +: acp_pkg::WORD_W];
				end
			end
		end
	endgenerate

	// ============================================================
	// readout; independent of the start pins
	logic [2:0]                  chIdx_q;
	logic                        byteSecond_q;
	logic [3:0]                  bitCnt_q;
	logic [acp_pkg::WORD_W-1:0]  shiftA_q;
	logic [acp_pkg::WORD_W-1:0]  shiftB_q;

	wire [2:0] chNext     = chIdx_q + 3'h1;
	wire       serLast    = (bitCnt_q == 4'(acp_pkg::BIT_LAST));
	wire       serMore    = (chNext < 3'(acp_pkg::HALF_CH));
	wire [acp_pkg::WORD_W-1:0] serNextA = serMore ? results_q[chNext] : acp_pkg::WORD_ZERO;
	wire [acp_pkg::WORD_W-1:0] serNextB = serMore ?
		results_q[3'(chNext + 3'(acp_pkg::HALF_CH))] : acp_pkg::WORD_ZERO;
	wire       parIdxOk   = (chIdx_q < 3'(acp_pkg::CHANNELS));
	wire [acp_pkg::WORD_W-1:0] parWord = parIdxOk ? results_q[chIdx_q] : acp_pkg::WORD_ZERO;
	wire       upperNow   = byteSecond_q ^ acp_pkg::BYTE_MSB_1ST;
	wire [7:0] byteNow    = upperNow ? parWord[15:8] : parWord[7:0];
	wire       readStrobe = ~pinsS.csN & rdFall & ~isSerial; // RULE14 RULE20
	wire       serClock   = ~pinsS.csN & sclkRise & isSerial; // RULE21
	// bus drives only while chip select and strobe are low, outside serial mode
	wire [acp_pkg::WORD_W-1:0] dbOeD = (~pinsS.csN & ~pinsS.rdSclk & ~isSerial) ?
		(isByte ? acp_pkg::OE_BYTE : acp_pkg::OE_ALL) : acp_pkg::OE_NONE; // RULE20

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			dbOe <= acp_pkg::OE_NONE;
		end else begin
			dbOe <= dbOeD; // RULE20 RULE23
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			chIdx_q      <= '0;
			byteSecond_q <= 1'b0;
			bitCnt_q     <= '0;
			shiftA_q     <= acp_pkg::WORD_ZERO;
			shiftB_q     <= acp_pkg::WORD_ZERO;
			dbOut        <= acp_pkg::WORD_ZERO;
			doutA        <= 1'b0;
			doutB        <= 1'b0;
			doutOe       <= 1'b0;
			firstData    <= 1'b0;
		end else if (digReset) begin
			chIdx_q      <= '0;
			byteSecond_q <= 1'b0;
			bitCnt_q     <= '0;
			shiftA_q     <= acp_pkg::WORD_ZERO; // RULE18
			shiftB_q     <= acp_pkg::WORD_ZERO; // RULE18
			dbOut        <= acp_pkg::WORD_ZERO; // RULE18
			doutA        <= 1'b0;
			doutB        <= 1'b0;
			doutOe       <= 1'b0;
			firstData    <= 1'b0;
		end else if (csRise) begin
			doutOe    <= 1'b0; // RULE23
			firstData <= 1'b0;
		end else if (csFall) begin
			chIdx_q      <= '0; // RULE23
			byteSecond_q <= 1'b0;
			bitCnt_q     <= '0;
			if (isSerial) begin
				shiftA_q  <= results_q[0];
				shiftB_q  <= results_q[acp_pkg::HALF_CH];
				doutA     <= results_q[0][acp_pkg::BIT_LAST];
				doutB     <= results_q[acp_pkg::HALF_CH][acp_pkg::BIT_LAST];
				doutOe    <= 1'b1; // RULE23
				firstData <= 1'b1;
			end
		end else if (readStrobe) begin
			firstData <= (chIdx_q == 3'h0);
			if (isByte) begin
				dbOut        <= {acp_pkg::BYTE_ZERO, byteNow};
				byteSecond_q <= ~byteSecond_q;
				if (byteSecond_q) begin
					chIdx_q <= chNext;
				end
			end else begin
				dbOut   <= parWord;
				chIdx_q <= chNext;
			end
		end else if (serClock) begin
			bitCnt_q <= bitCnt_q + 4'h1; // RULE21
			if (serLast) begin
				// line A carries the low group, line B the high group
				chIdx_q   <= chNext;
				shiftA_q  <= serNextA;
				shiftB_q  <= serNextB;
				doutA     <= serNextA[acp_pkg::BIT_LAST];
				doutB     <= serNextB[acp_pkg::BIT_LAST];
				firstData <= 1'b0;
			end else begin
				shiftA_q <= {shiftA_q[acp_pkg::BIT_LAST-1:0], 1'b0};
				shiftB_q <= {shiftB_q[acp_pkg::BIT_LAST-1:0], 1'b0};
				doutA    <= shiftA_q[acp_pkg::BIT_LAST-1];
				doutB    <= shiftB_q[acp_pkg::BIT_LAST-1];
			end
		end
	end
endmodule // acp_control_pins

// file: sim/acp_host_model.sv
`timescale 1ns/10ps
// ============================================================
// host side of the readout pins: chip select and strobe or serial clock
module acp_host_model (
	input  wire logic        clk_sys,
	input  wire logic [15:0] dbOut,
	input  wire logic [15:0] dbOe,
	input  wire logic        doutA,
	input  wire logic        doutB,
	input  wire logic        doutOe,
	input  wire logic        firstData,
	output logic             csN,
	output logic             rdSclk
);
	logic [15:0] lowDb, lowOe;
	logic        lowA, lowB, lowFirst, highA, highFirst;
	// released pins read back inverted, so data taken off a dead bus shows up
	wire  [15:0] busPins = ~(dbOut ^ dbOe);
	wire         lineA   = doutOe ? doutA : ~doutA;
	wire         lineB   = doutOe ? doutB : ~doutB;

	// strobe and clock rest high, so nothing moves outside a frame
	initial begin
		csN = 1'b1;
		rdSclk = 1'b1;
	end

	// open or close a frame, then let the device see the change
	task automatic frame(input logic open);
		@(negedge clk_sys);
		csN = !open;
		repeat (8) @(negedge clk_sys);
	endtask

	// one 320 ns period; the low half is sampled just before the rising edge
	task automatic pulse();
		rdSclk = 1'b0;
		repeat (5) @(negedge clk_sys);
		{lowDb, lowOe, lowA, lowB, lowFirst} = {busPins, dbOe, lineA, lineB, firstData};
		rdSclk = 1'b1;
		repeat (3) @(negedge clk_sys);
		{highA, highFirst} = {lineA, firstData};
	endtask
endmodule // acp_host_model

// file: sim/acp_control_pins_properties.sv
`timescale 1ns/10ps
// ============================================================
// pin-level checks of the control block
module acp_control_pins_properties (
	input wire logic                 clk_sys,
	input wire logic                 resetn,
	input wire logic                 referenceSelect,
	input wire logic                 rangeSelect,
	input wire logic                 standbyN,
	input wire logic                 interfaceSelect,
	input wire logic                 conversionStartA,
	input wire logic                 resetPin,
	input wire logic                 csN,
	input wire logic                 rdSclk,
	input wire logic                 busy,
	input wire logic                 holdA,
	input wire logic                 holdB,
	input wire logic                 dataValid,
	input wire acp_pkg::acp_analog_t analog,
	input wire logic [15:0]          dbOe,
	input wire logic                 doutOe
);
	localparam int BUSY_LEN = acp_pkg::CONV_CYCLES;
	logic [7:0]          busyCnt_q, busyCnt_d;
	acp_pkg::acp_power_t expPower;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	// busy length counter, cleared whenever busy drops
	assign busyCnt_d = busy ? busyCnt_q + 8'h01 : 8'h00;
	assign expPower = standbyN ? acp_pkg::PWR_NORMAL : (rangeSelect == acp_pkg::STANDBY_N_INPUT_RANGE) ?
		acp_pkg::PWR_STANDBY : acp_pkg::PWR_SHUTDOWN;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			busyCnt_q <= 8'h00;
		else
			busyCnt_q <= busyCnt_d;
	end

	// ============================================================
	// analog steering; pins are given six cycles to pass the synchronisers
	AST_REF_BUF: assert property ($past(resetn, 3) && analog.powerState != acp_pkg::PWR_SHUTDOWN
		|-> analog.refBufferOn) else $error("reference buffer off");
	AST_REF_SEL: assert property ($stable(referenceSelect)[*6] ##0
		(analog.powerState != acp_pkg::PWR_SHUTDOWN) |-> analog.bandgapOn == referenceSelect)
		else $error("band-gap does not follow reference select");
	AST_RANGE: assert property ($stable(rangeSelect)[*6] |-> analog.rangeTenVolt == rangeSelect)
		else $error("range does not follow range select");
	AST_POWER: assert property (($stable(standbyN) && $stable(rangeSelect))[*6]
		|-> analog.powerState == expPower) else $error("wrong power state");
	// ============================================================
	// conversion control
	AST_HOLD_A: assert property ($rose(conversionStartA) && !busy && !holdA && !resetPin
		|-> ##[2:5] holdA) else $error("group A not held after start");
	AST_BUSY_BOTH: assert property ($rose(busy) |-> holdA && holdB)
		else $error("busy without both groups held");
	AST_BUSY_LEN: assert property ($fell(busy) && dataValid |-> busyCnt_q == BUSY_LEN)
		else $error("busy length wrong");
	AST_PIN_RESET: assert property (resetPin[*5] |-> !busy && !holdA && !holdB && !dataValid
		&& !doutOe) else $error("reset pin did not clear");
	// ============================================================
	// output enables
	AST_BUS_IDLE: assert property ((csN || rdSclk)[*5] |-> dbOe == acp_pkg::OE_NONE)
		else $error("bus driven without select and strobe");
	AST_BUS_PAR: assert property ((!csN && !rdSclk && !interfaceSelect)[*5]
		|-> dbOe == acp_pkg::OE_ALL) else $error("parallel bus not driven");
	AST_SER_IDLE: assert property (csN[*5] |-> !doutOe)
		else $error("serial outputs driven outside a frame");

	COV_CONV: cover property ($fell(busy) && dataValid);
	COV_PAR: cover property (dbOe == acp_pkg::OE_ALL);
	COV_SER: cover property (doutOe);
endmodule // acp_control_pins_properties

bind acp_control_pins acp_control_pins_properties u_acp_control_pins_properties (
	.clk_sys(clk_sys), .resetn(resetn), .referenceSelect(referenceSelect),
	.rangeSelect(rangeSelect), .standbyN(standbyN), .interfaceSelect(interfaceSelect),
	.conversionStartA(conversionStartA), .resetPin(resetPin), .csN(csN), .rdSclk(rdSclk),
	.busy(busy), .holdA(holdA), .holdB(holdB), .dataValid(dataValid), .analog(analog),
	.dbOe(dbOe), .doutOe(doutOe));

// file: sim/acp_control_pins_tb.sv
`timescale 1ns/10ps
`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin \
	errors++; $display("wrong value at %0t: %s", $time, m); end end

// ============================================================
// pin-driven bench: mode, power, conversion and all three readouts
module acp_control_pins_tb;
	localparam int RECOVERY = 50; // power-down exit wait, plain default
	logic                 clk_sys, resetn, referenceSelect, rangeSelect, standbyN;
	logic                 interfaceSelect, byteModeSelect, conversionStartA, conversionStartB;
	logic                 resetPin, csN, rdSclk, busy, holdA, holdB, dataValid;
	logic                 doutA, doutB, doutOe, firstData;
	logic [95:0]          convResult;
	logic [15:0]          dbOut, dbOe;
	logic [15:0]          res [6];
	acp_pkg::acp_analog_t analog;
	int                   errors, check_count, cycles;

	acp_control_pins u_acp_control_pins (.clk_sys(clk_sys), .resetn(resetn),
		.referenceSelect(referenceSelect), .rangeSelect(rangeSelect), .standbyN(standbyN),
		.interfaceSelect(interfaceSelect), .byteModeSelect(byteModeSelect),
		.conversionStartA(conversionStartA), .conversionStartB(conversionStartB),
		.resetPin(resetPin), .csN(csN), .rdSclk(rdSclk), .convResult(convResult),
		.busy(busy), .holdA(holdA), .holdB(holdB), .dataValid(dataValid), .analog(analog),
		.dbOut(dbOut), .dbOe(dbOe), .doutA(doutA), .doutB(doutB), .doutOe(doutOe),
		.firstData(firstData));
	acp_host_model u_acp_host_model (.clk_sys(clk_sys), .dbOut(dbOut), .dbOe(dbOe),
		.doutA(doutA), .doutB(doutB), .doutOe(doutOe), .firstData(firstData), .csN(csN),
		.rdSclk(rdSclk));

	// 25 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// hang guard; the whole run needs well under ten thousand cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 30000) begin
			errors++;
			conclude();
		end
	end

	task automatic conclude();
		$display("checks %0d, mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// pins pass synchronisers before the outputs move
	task automatic settle();
		repeat (8) @(negedge clk_sys);
	endtask

	// device reset pulse, then the quiet time before any start edge
	task automatic pinReset();
		resetPin = 1'b1;
		repeat (6) @(negedge clk_sys);
		resetPin = 1'b0;
		repeat (10) @(negedge clk_sys);
	endtask

	initial begin
		res = '{16'h9a31, 16'h4c02, 16'he7d5, 16'h1b6f, 16'h80f1, 16'h5e28};
		convResult = {res[5], res[4], res[3], res[2], res[1], res[0]};
		{referenceSelect, rangeSelect, standbyN, interfaceSelect, byteModeSelect} = 5'b10100;
		{conversionStartA, conversionStartB, resetPin, resetn} = 4'b0000;
		repeat (12) @(negedge clk_sys);
		resetn = 1'b1;
		pinReset();
		// every reference and range level in normal operation
		for (int i = 0; i < 4; i++) begin
			{rangeSelect, referenceSelect} = i[1:0];
			settle();
			`CHK(analog.internalRefEn, i[0], "internal reference")
			`CHK(analog.bandgapOn, i[0], "band-gap")
			`CHK(analog.refBufferOn, 1'b1, "reference buffer")
			`CHK(analog.rangeTenVolt, i[1], "range")
		end
		$display("test analog done");
		// range low gives shutdown, range high standby
		referenceSelect = 1'b1;
		for (int i = 0; i < 2; i++) begin
			rangeSelect = i[0];
			standbyN = !standbyN;
			settle();
			`CHK(analog.powerState, i ? acp_pkg::PWR_STANDBY : acp_pkg::PWR_SHUTDOWN, "power")
			`CHK({analog.regulatorsOn, analog.bandgapOn}, {i[0], i[0]}, "kept supplies")
			standbyN = !standbyN;
			repeat (RECOVERY) @(negedge clk_sys);
		end
		`CHK(analog.powerState, acp_pkg::PWR_NORMAL, "normal again")
		pinReset();
		rangeSelect = 1'b0;
		repeat (2000) @(negedge clk_sys);
		$display("test power done");
		// groups held one by one; busy only once both are held
		conversionStartA = 1'b1;
		settle();
		`CHK({holdA, holdB, busy}, 3'b100, "group A held")
		conversionStartB = 1'b1;
		settle();
		`CHK({holdA, holdB, busy}, 3'b111, "both held")
		// a fresh start edge while busy must not disturb the conversion
		conversionStartA = 1'b0;
		repeat (4) @(negedge clk_sys);
		conversionStartA = 1'b1;
		repeat (30) @(negedge clk_sys);
		`CHK(busy, 1'b1, "still converting")
		for (int i = 0; i < 200 && busy !== 1'b0; i++) @(negedge clk_sys);
		`CHK({busy, holdA, dataValid}, 3'b001, "conversion end")
		// later reads must show the latched words, not the live inputs
		convResult = ~convResult;
		$display("test conversion done");
		// word reads with the starts still high
		u_acp_host_model.frame(1'b1);
		for (int k = 0; k < 6; k++) begin
			u_acp_host_model.pulse();
			`CHK(u_acp_host_model.lowOe, acp_pkg::OE_ALL, "bus enable")
			`CHK(u_acp_host_model.lowDb, res[k], "parallel word")
			`CHK(u_acp_host_model.lowFirst, k == 0, "first flag")
		end
		u_acp_host_model.frame(1'b0);
		`CHK(dbOe, acp_pkg::OE_NONE, "bus released")
		{conversionStartA, conversionStartB} = 2'b00;
		// byte reads, upper byte first
		{interfaceSelect, byteModeSelect} = 2'b11;
		settle();
		u_acp_host_model.frame(1'b1);
		for (int k = 0; k < 12; k++) begin
			u_acp_host_model.pulse();
			`CHK(u_acp_host_model.lowOe, acp_pkg::OE_BYTE, "byte enable")
			`CHK(u_acp_host_model.lowDb[7:0], k[0] ? res[k/2][7:0] : res[k/2][15:8], "byte")
			`CHK(u_acp_host_model.lowFirst, k < 2, "byte first flag")
		end
		u_acp_host_model.frame(1'b0);
		// serial: channel 1 on A, channel 4 on B, shifted on rising edges
		byteModeSelect = 1'b0;
		settle();
		u_acp_host_model.frame(1'b1);
		`CHK(doutOe, 1'b1, "serial enable")
		for (int b = 0; b < 16; b++) begin
			u_acp_host_model.pulse();
			`CHK(u_acp_host_model.lowA, res[0][15-b], "serial A bit")
			`CHK(u_acp_host_model.lowB, res[3][15-b], "serial B bit")
			`CHK(u_acp_host_model.highFirst, b < 15, "serial first flag")
		end
		`CHK(u_acp_host_model.highA, res[1][15], "next channel")
		u_acp_host_model.frame(1'b0);
		`CHK(doutOe, 1'b0, "serial released")
		$display("test readout done");
		// reset pin in mid-read clears the output word
		interfaceSelect = 1'b0;
		settle();
		u_acp_host_model.frame(1'b1);
		u_acp_host_model.pulse();
		u_acp_host_model.pulse();
		pinReset();
		`CHK({dbOut, dataValid}, {acp_pkg::WORD_ZERO, 1'b0}, "read reset")
		u_acp_host_model.frame(1'b0);
		// reset pin in mid-conversion aborts it
		conversionStartA = 1'b1;
		conversionStartB = conversionStartA;
		settle();
		`CHK(busy, 1'b1, "second conversion")
		pinReset();
		`CHK({busy, holdA, holdB, dataValid}, 4'b0000, "aborted")
		{conversionStartA, conversionStartB} = 2'b00;
		settle();
		$display("test reset done");
		conclude();
	end
endmodule // acp_control_pins_tb
